// File: shared/adcreg_pkg.sv
// constants and types for the converter control register block
package adcreg_pkg;
   // register byte addresses on the bus
   localparam logic [3:0] ADDR_CONTROL_0 = 4'h0;
   localparam logic [3:0] ADDR_SOURCE_CLOCK = 4'h4;
   localparam logic [3:0] ADDR_AMP_REF = 4'h8;
   localparam logic [3:0] ADDR_RESULT_LOW = 4'hc;
   localparam logic [3:0] ADDR_RESULT_HIGH = 4'h0 + 4'h0;
   // result high byte sits above the low one
   localparam logic [4:0] ADDR_RESULT_HIGH_W = 5'h10;
   localparam int ADDR_BITS = 5;
   // control 0 fields
   localparam int BIT_START = 7;
   localparam int BIT_BUSY = 6;
   localparam int BIT_ENABLE = 5;
   localparam int BIT_JUSTIFY = 4;
   // source and clock select fields
   localparam int BIT_UNUSED_SRC = 3;
   // amplifier and reference: bit 6 unimplemented
   localparam logic [7:0] AMP_REF_MASK = 8'hbf;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // conversion length in converter clocks
   localparam logic [4:0] CONV_CLOCKS = 5'h10;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // analog source routing
   typedef enum logic [2:0] {
      ADCREG_SRC_EXTERNAL, ADCREG_SRC_SUPPLY, ADCREG_SRC_AMP,
      ADCREG_SRC_REGULATOR, ADCREG_SRC_GROUND
   } adcreg_src_type;
endpackage

// File: hw/adcreg_clkdiv.sv
// converter clock enable divider
`timescale 1ns/1ps
module adcreg_clkdiv (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic run,
   input wire logic [2:0] rate,
   // enable out
   output logic tick
);
   logic [6:0] count_reg;
   logic [6:0] limit;

   assign limit = 7'((8'h01 << rate) - 8'h01);

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         count_reg <= 7'h00;
         tick <= 1'b0;
      end else if (count_reg >= limit) begin
         count_reg <= 7'h00;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 7'h01;
         tick <= 1'b0;
      end
   end
endmodule // adcreg_clkdiv

// File: hw/adcreg_top.sv
// converter control and result registers behind an axi4-lite slave
`timescale 1ns/1ps
// Operation
// - justify 0: high byte D11..4, low D3..0<<4
// - start bit rising then falling starts conversion
// - busy clears when conversion completes
// - busy flag ignores software writes
// - results hold while converter disabled
// - channel code 0 and 1 route inputs
// - source codes 0,4,12-15 pick external channel
// - codes 1-3 supply, 5-7 amplifier divided
// - code 8 regulator tap, 9-11 ground
// - internal source disconnects external channel
// - clock rate divides system clock by 2^n
// - source register bit 3 reads zero
// - converter pin drops function and pull-high
// - gain field selects gains one to four
// - reference select supply, pin, amplifier
// - end of conversion raises interrupt request
module adcreg_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog converter core
   input wire logic [11:0] conv_data,
   output logic converter_power,
   output logic conv_clock_tick,
   output logic conv_sample,
   output adcreg_pkg::adcreg_src_type source_route,
   output logic [1:0] source_divide,
   output logic external_input_zero,
   output logic external_input_one,
   output logic [1:0] amplifier_gain_select,
   output logic [1:0] reference_select,
   output logic amplifier_enable,
   output logic amplifier_input_select,
   // pin sharing and interrupt request
   input wire logic [1:0] pin_is_analog,
   output logic [1:0] pin_function_off,
   output logic [1:0] pin_pullhigh_off,
   output logic conv_done_irq
);
   import adcreg_pkg::*;

   function automatic logic [7:0] merge(input logic [7:0] old,
         input logic [7:0] val, input logic en);
      merge = en ? val : old;
   endfunction

   function automatic logic is_external(input logic [3:0] code);
      is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
   endfunction

   //----------------------------------------
   // registers
   //----------------------------------------
   logic start_reg;
   logic busy_reg;
   logic enable_reg;
   logic justify_reg;
   logic [3:0] channel_reg;
   logic [3:0] source_reg;
   logic [2:0] rate_reg;
   logic [7:0] amp_ref_reg;
   logic [7:0] result_low_reg;
   logic [7:0] result_high_reg;
   logic [4:0] clocks_reg;
   logic tick;
   logic wr_fire;
   logic start_fall;
   logic done;
   logic [4:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic w_lane_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [7:0] ctrl0_next;
   logic [7:0] read_byte;
   logic read_hit;

   //----------------------------------------
   // axi4-lite write
   //----------------------------------------
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_data_reg <= 32'h00000000;
         w_lane_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_lane_reg <= s_axi_wstrb[0];
            w_have_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg == {1'b0, ADDR_CONTROL_0} ||
               aw_addr_reg == {1'b0, ADDR_SOURCE_CLOCK} ||
               aw_addr_reg == {1'b0, ADDR_AMP_REF} ||
               aw_addr_reg == {1'b0, ADDR_RESULT_LOW} ||
               aw_addr_reg == ADDR_RESULT_HIGH_W) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   //----------------------------------------
   // control registers
   //----------------------------------------
   assign ctrl0_next = merge({start_reg, busy_reg, enable_reg, justify_reg,
      channel_reg}, w_data_reg[7:0],
      wr_fire && w_lane_reg && aw_addr_reg == {1'b0, ADDR_CONTROL_0});
   assign start_fall = start_reg && !ctrl0_next[BIT_START];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_reg <= CTRL_RESET[BIT_START];
         enable_reg <= CTRL_RESET[BIT_ENABLE];
         justify_reg <= CTRL_RESET[BIT_JUSTIFY];
         channel_reg <= CTRL_RESET[3:0];
      end else begin
         // busy bit of the written byte is dropped
         start_reg <= ctrl0_next[BIT_START];
         enable_reg <= ctrl0_next[BIT_ENABLE];
         justify_reg <= ctrl0_next[BIT_JUSTIFY];
         channel_reg <= ctrl0_next[3:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_reg <= CTRL_RESET[7:4];
         rate_reg <= CTRL_RESET[2:0];
         amp_ref_reg <= CTRL_RESET;
      end else if (wr_fire && w_lane_reg) begin
         if (aw_addr_reg == {1'b0, ADDR_SOURCE_CLOCK}) begin
            source_reg <= w_data_reg[7:4];
            rate_reg <= w_data_reg[2:0];
         end
         if (aw_addr_reg == {1'b0, ADDR_AMP_REF}) begin
            amp_ref_reg <= w_data_reg[7:0] & AMP_REF_MASK;
         end
      end
   end

   //----------------------------------------
   // conversion sequencer
   //----------------------------------------
   adcreg_clkdiv u_clkdiv (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(busy_reg),
      .rate(rate_reg),
      .tick(tick)
   );

   assign done = busy_reg && tick && clocks_reg == CONV_CLOCKS - 5'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'b0;
         clocks_reg <= 5'h00;
         conv_done_irq <= 1'b0;
         conv_sample <= 1'b0;
      end else begin
         conv_done_irq <= 1'b0;
         conv_sample <= 1'b0;
         if (start_fall && enable_reg) begin
            busy_reg <= 1'b1;
            clocks_reg <= 5'h00;
         end else if (done) begin
            busy_reg <= 1'b0;
            conv_done_irq <= 1'b1;
            conv_sample <= 1'b1;
         end else if (busy_reg && tick) begin
            clocks_reg <= clocks_reg + 5'h01;
         end
         if (!enable_reg) begin
            busy_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_low_reg <= CTRL_RESET;
         result_high_reg <= CTRL_RESET;
      end else if (done && enable_reg && !(start_fall)) begin
         if (justify_reg) begin
            result_high_reg <= {4'h0, conv_data[11:8]};
            result_low_reg <= conv_data[7:0];
         end else begin
            result_high_reg <= conv_data[11:4];
            result_low_reg <= {conv_data[3:0], 4'h0};
         end
      end
   end

   //----------------------------------------
   // analog routing
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_route <= ADCREG_SRC_EXTERNAL;
         source_divide <= 2'h0;
         external_input_zero <= 1'b0;
         external_input_one <= 1'b0;
         converter_power <= 1'b0;
         conv_clock_tick <= 1'b0;
         amplifier_gain_select <= 2'h0;
         reference_select <= 2'h0;
         amplifier_enable <= 1'b0;
         amplifier_input_select <= 1'b0;
         pin_function_off <= 2'h0;
         pin_pullhigh_off <= 2'h0;
      end else begin
         converter_power <= enable_reg;
         conv_clock_tick <= tick && busy_reg;
         amplifier_gain_select <= amp_ref_reg[1:0];
         reference_select <= amp_ref_reg[3:2];
         amplifier_input_select <= amp_ref_reg[4];
         amplifier_enable <= amp_ref_reg[7];
         pin_function_off <= pin_is_analog;
         pin_pullhigh_off <= pin_is_analog;
         source_divide <= 2'h0;
         if (is_external(source_reg)) begin
            source_route <= ADCREG_SRC_EXTERNAL;
         end else if (source_reg[3:2] == 2'b00) begin
            source_route <= ADCREG_SRC_SUPPLY;
            source_divide <= source_reg[1:0] - 2'h1;
         end else if (source_reg[3:2] == 2'b01) begin
            source_route <= ADCREG_SRC_AMP;
            source_divide <= source_reg[1:0] - 2'h1;
         end else if (source_reg == 4'h8) begin
            source_route <= ADCREG_SRC_REGULATOR;
         end else begin
            source_route <= ADCREG_SRC_GROUND;
         end
         external_input_zero <= is_external(source_reg) && channel_reg == 4'h0;
         external_input_one <= is_external(source_reg) && channel_reg == 4'h1;
      end
   end

   //----------------------------------------
   // axi4-lite read
   //----------------------------------------
   always_comb begin
      read_byte = 8'h00;
      read_hit = 1'b1;
      if (s_axi_araddr == {1'b0, ADDR_CONTROL_0}) begin
         read_byte = {start_reg, busy_reg, enable_reg, justify_reg,
            channel_reg};
      end else if (s_axi_araddr == {1'b0, ADDR_SOURCE_CLOCK}) begin
         read_byte = {source_reg, 1'b0, rate_reg};
      end else if (s_axi_araddr == {1'b0, ADDR_AMP_REF}) begin
         read_byte = amp_ref_reg;
      end else if (s_axi_araddr == {1'b0, ADDR_RESULT_LOW}) begin
         read_byte = result_low_reg;
      end else if (s_axi_araddr == ADDR_RESULT_HIGH_W) begin
         read_byte = result_high_reg;
      end else begin
         read_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, read_byte};
         s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   //----------------------------------------
   // checks
   //----------------------------------------
   busy_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      start_fall && enable_reg |=> busy_reg)
      else $error("busy not set after start");
   busy_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      done && !start_fall |=> !busy_reg && conv_done_irq)
      else $error("busy not cleared at completion");
   busy_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !busy_reg && !(start_fall && enable_reg) |=> !busy_reg)
      else $error("busy changed without conversion");
   hold_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable_reg |=> $stable(result_low_reg) && $stable(result_high_reg))
      else $error("result changed while disabled");
   left_just_a: assert property (@(posedge aclk) disable iff (!aresetn)
      done && enable_reg && !start_fall && !justify_reg
      |=> result_high_reg == $past(conv_data[11:4]) &&
      result_low_reg[3:0] == 4'h0)
      else $error("left justified result wrong");
   right_just_a: assert property (@(posedge aclk) disable iff (!aresetn)
      done && enable_reg && !start_fall && justify_reg
      |=> result_high_reg[7:4] == 4'h0 &&
      result_low_reg == $past(conv_data[7:0]))
      else $error("right justified result wrong");
   ext_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !is_external(source_reg) |=> !external_input_zero &&
      !external_input_one)
      else $error("external input left connected");
   restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_reg && start_fall && enable_reg |=> busy_reg &&
      clocks_reg == 5'h00)
      else $error("restart did not reset conversion");
   bit3_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == {1'b0, ADDR_SOURCE_CLOCK}
      |=> s_axi_rdata[BIT_UNUSED_SRC] == 1'b0)
      else $error("unused source bit read nonzero");
endmodule // adcreg_top

// File: tb/adcreg_conv_model.sv
// behavioural analog converter core that feeds the result lines
`timescale 1ns/1ps
module adcreg_conv_model (
   // clock
   input wire logic aclk,
   // converter power from the block
   input wire logic converter_power,
   // level to convert, set by the bench
   input wire logic [11:0] level,
   // result to the block
   output logic [11:0] conv_data
);
   logic [11:0] flip_reg = 12'h000;
   // unpowered core: lines toggle, never a stale result
   always @(posedge aclk) begin
      flip_reg <= ~flip_reg;
   end
   assign conv_data = converter_power ? level : (flip_reg ^ level);
endmodule // adcreg_conv_model

// File: tb/adcreg_top_test.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
module adcreg_top_test;
   import adcreg_pkg::*;
   localparam logic [4:0] A_C0 = {1'b0, ADDR_CONTROL_0};
   localparam logic [4:0] A_SC = {1'b0, ADDR_SOURCE_CLOCK};
   localparam logic [4:0] A_AR = {1'b0, ADDR_AMP_REF};
   localparam logic [4:0] A_LO = {1'b0, ADDR_RESULT_LOW};
   localparam logic [2:0] RT [16] = '{0,1,1,1,0,2,2,2,3,4,4,4,0,0,0,0};
   localparam logic [1:0] DV [16] = '{3,0,1,2,3,0,1,2,3,3,3,3,3,3,3,3};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [11:0] conv_data, level = 12'h000;
   logic converter_power, conv_clock_tick, conv_sample, conv_done_irq;
   adcreg_src_type source_route;
   logic [1:0] source_divide, amplifier_gain_select, reference_select;
   logic external_input_zero, external_input_one;
   logic amplifier_enable, amplifier_input_select;
   logic [1:0] pin_is_analog = 2'h0, pin_function_off, pin_pullhigh_off;
   int miscompares = 0, check_count = 0;
   int ticks = 0, gap = 0, since = 0, irqs = 0, samples = 0;
   always #25 aclk = ~aclk;
   adcreg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_data,
      .converter_power, .conv_clock_tick, .conv_sample, .source_route,
      .source_divide, .external_input_zero, .external_input_one,
      .amplifier_gain_select, .reference_select, .amplifier_enable,
      .amplifier_input_select, .pin_is_analog, .pin_function_off,
      .pin_pullhigh_off, .conv_done_irq);
   adcreg_conv_model core (.aclk, .converter_power, .level, .conv_data);
   // converter clock spacing and completion events
   always @(posedge aclk) begin
      if (conv_clock_tick === 1'b1) begin
         ticks++;
         gap = since;
         since = 1;
      end else since++;
      if (conv_done_irq === 1'b1) irqs++;
      if (conv_sample === 1'b1) samples++;
   end
   // ------------------------------
   // bus tasks
   // ------------------------------
   task automatic chk(input string n, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic axw(input logic [4:0] a, input logic [7:0] d,
                      input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bvalid", s_axi_bvalid, 1'b1);
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic axr(input logic [4:0] a, output logic [7:0] d,
                      input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata[7:0];
      chk("rvalid", s_axi_rvalid, 1'b1);
      chk("rresp", s_axi_rresp, er);
      chk("rdata_upper", s_axi_rdata[31:8], 24'h0);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
      logic [7:0] d;
      axr(a, d, RESP_OKAY);
      chk(n, d, e);
   endtask
   task automatic go(input logic [7:0] c);
      axw(A_C0, c | 8'h80, RESP_OKAY);
      axw(A_C0, c, RESP_OKAY);
   endtask
   task automatic idle(output logic [7:0] d);
      do begin
         axr(A_C0, d, RESP_OKAY);
      end while (d[BIT_BUSY] !== 1'b0);
   endtask
   task automatic conv(input logic [2:0] r, input logic j,
                       input logic [11:0] v);
      logic [7:0] d;
      int t0, i0, s0;
      level <= v;
      axw(A_SC, {5'h00, r}, RESP_OKAY);
      axw(A_C0, {3'h1, j, 4'h0}, RESP_OKAY);
      t0 = ticks;
      i0 = irqs;
      s0 = samples;
      go({3'h1, j, 4'h0});
      rd(A_C0, {3'h3, j, 4'h0}, "busy_set");
      idle(d);
      chk("busy_clear", d, {3'h1, j, 4'h0});
      chk("ticks", ticks - t0, CONV_CLOCKS);
      chk("tick_gap", gap, 32'h1 << r);
      chk("irq", irqs - i0, 1);
      chk("sample", samples - s0, 1);
      rd(ADDR_RESULT_HIGH_W, j ? {4'h0, v[11:8]} : v[11:4], "hi");
      rd(A_LO, j ? v[7:0] : {v[3:0], 4'h0}, "lo");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      logic [7:0] d;
      int i0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_C0, CTRL_RESET, "c0_rst");
      rd(A_SC, CTRL_RESET, "sc_rst");
      rd(A_AR, CTRL_RESET, "ar_rst");
      axr(5'h14, d, RESP_SLVERR);
      axw(5'h14, 8'hff, RESP_SLVERR);
      axw(A_SC, 8'hff, RESP_OKAY);
      rd(A_SC, 8'hf7, "sc_bit3");
      axw(A_C0, 8'h60, RESP_OKAY);
      rd(A_C0, 8'h20, "busy_write");
      axw(A_AR, 8'hff, RESP_OKAY);
      rd(A_AR, 8'hbf, "ar_rw");
      chk("gain", {amplifier_gain_select, reference_select}, 4'hf);
      chk("amp", {amplifier_enable, amplifier_input_select}, 2'h3);
      axw(A_AR, 8'h06, RESP_OKAY);
      rd(A_AR, 8'h06, "ar_rw2");
      chk("gain2", {amplifier_gain_select, reference_select}, 4'h9);
      axw(A_C0, 8'h01, RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
         axw(A_SC, {i[3:0], 4'h0}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk("route", source_route, RT[i]);
         chk("ext_one", external_input_one, RT[i] == 3'h0);
         chk("ext_zero", external_input_zero, 1'b0);
         if (DV[i] != 2'h3) chk("divide", source_divide, DV[i]);
      end
      axw(A_SC, 8'h00, RESP_OKAY);
      axw(A_C0, 8'h00, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("ch0", {external_input_zero, external_input_one}, 2'h2);
      axw(A_C0, 8'h02, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("ch2", {external_input_zero, external_input_one}, 2'h0);
      for (int i = 1; i < 3; i++) begin
         pin_is_analog <= i[1:0];
         repeat (3) @(posedge aclk);
         chk("pin_fn", pin_function_off, i[1:0]);
         chk("pin_pull", pin_pullhigh_off, i[1:0]);
      end
      for (int r = 0; r < 8; r++) conv(r[2:0], r[0], 12'h9c3 ^ {4{r[2:0]}});
      conv(3'h0, 1'b1, 12'habc);
      axw(A_C0, 8'h10, RESP_OKAY);
      level <= 12'h5a5;
      go(8'h10);
      rd(A_C0, 8'h10, "off_idle");
      chk("power", converter_power, 1'b0);
      rd(ADDR_RESULT_HIGH_W, 8'h0a, "hold_hi");
      rd(A_LO, 8'hbc, "hold_lo");
      axw(A_SC, 8'h03, RESP_OKAY);
      axw(A_C0, 8'h20, RESP_OKAY);
      i0 = irqs;
      go(8'h20);
      repeat (40) @(posedge aclk);
      go(8'h20);
      rd(A_C0, 8'h60, "restart_busy");
      chk("no_irq_yet", irqs - i0, 0);
      idle(d);
      chk("restart_irq", irqs - i0, 1);
      rd(A_LO, 8'h50, "restart_lo");
      test_done;
   end
   initial begin
      repeat (60000) @(posedge aclk);
      miscompares++;
      test_done;
   end
endmodule // adcreg_top_test
